// file: src/mode_sel_pkg.sv
// Package of constants and carrier types for the control mode selector
package mode_sel_pkg;

	// Combined-mode codes
	localparam logic [7:0] CODE_PULSE_SPEED = 8'h06;
	localparam logic [7:0] CODE_PULSE_TORQUE = 8'h07;
	localparam logic [7:0] CODE_TABLE_SPEED = 8'h08;
	localparam logic [7:0] CODE_TABLE_TORQUE = 8'h09;
	localparam logic [7:0] CODE_SPEED_TORQUE = 8'h0a;
	localparam logic [7:0] CODE_PULSE_TABLE = 8'h0d;
	localparam logic [7:0] CODE_PULSE_TABLE_SPEED = 8'h0e;
	localparam logic [7:0] CODE_PULSE_TABLE_TORQUE = 8'h0f;

	// Register offsets
	localparam logic [11:0] ADDR_MODE = 12'h000;
	localparam logic [11:0] ADDR_LIMIT = 12'h004;
	localparam logic [11:0] ADDR_MAX_SPEED = 12'h008;
	localparam logic [11:0] ADDR_AVAIL = 12'h00c;
	localparam logic [11:0] ADDR_STATUS = 12'h010;
	localparam logic [11:0] ADDR_POS_TARGET = 12'h014;

	// Field positions
	localparam int LIMIT_SPEED_BIT = 0;
	localparam int LIMIT_TORQUE_BIT = 1;
	localparam int AVAIL_SPEED_BIT = 0;
	localparam int AVAIL_TORQUE_BIT = 1;
	localparam int MODE_ZERO_TORQUE_BIT = 8;

	// Reset values
	localparam logic [7:0] RST_MODE = 8'h06;
	localparam logic [1:0] RST_LIMIT = 2'h0;
	localparam logic [15:0] RST_MAX_SPEED = 16'hffff;
	localparam logic [1:0] RST_AVAIL = 2'h3;

	// Active control loop
	typedef enum logic [2:0] {
		LOOP_PULSE,
		LOOP_TABLE,
		LOOP_SPEED,
		LOOP_TORQUE,
		LOOP_HOLD
	} loop_t;

	// Command source: analog, zero or one of three presets
	typedef enum logic [2:0] {
		SRC_ANALOG,
		SRC_ZERO,
		SRC_PRESET1,
		SRC_PRESET2,
		SRC_PRESET3
	} src_t;

	// Digital selection inputs
	typedef struct packed {
		logic speed_or_position;
		logic speed_or_torque;
		logic torque_or_position;
		logic table_or_pulse;
		logic position_trigger;
		logic [1:0] speed_preset_select;
		logic [1:0] torque_preset_select;
		logic [5:0] position_preset_select;
	} sel_in_t;

	// Selection results
	typedef struct packed {
		loop_t loop;
		src_t speed_src;
		src_t torque_src;
		logic speed_limit_on;
		logic torque_limit_on;
		logic [15:0] speed_cap;
		logic [5:0] position_index;
		logic position_move;
	} sel_out_t;

endpackage

// file: src/servo_control_mode_selector.sv
// Control loop selector with limit gating and APB configuration slave
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module servo_control_mode_selector
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic servo_enable,
	input wire mode_sel_pkg::sel_in_t sel_in,
	output mode_sel_pkg::sel_out_t sel_out
);

	////////////////////////////////////////////////////////////////////
	// Registers
	logic [7:0] mode_ff;
	logic [1:0] limit_ff;
	logic [15:0] max_speed_ff;
	logic [1:0] avail_ff;
	mode_sel_pkg::sel_in_t sync1_ff;
	mode_sel_pkg::sel_in_t sync2_ff;
	logic trig_prev_ff;
	logic armed_ff;
	logic [5:0] target_ff;
	logic servo_s1_ff;
	logic servo_s2_ff;
	logic prev_position_ff;
	mode_sel_pkg::sel_out_t out_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;

	logic trig_rise;
	logic wr_en;
	logic rd_en;
	logic code_ok;
	logic in_position;
	mode_sel_pkg::loop_t nxt_loop;
	mode_sel_pkg::src_t nxt_speed_src;
	mode_sel_pkg::src_t nxt_torque_src;

	////////////////////////////////////////////////////////////////////
	// Input synchronisers
	// selection line sync
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= sel_in;
			sync2_ff <= sync1_ff;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			servo_s1_ff <= 1'b0;
			servo_s2_ff <= 1'b0;
		end
		else
		begin
			servo_s1_ff <= servo_enable;
			servo_s2_ff <= servo_s1_ff;
		end
	end

	// Trigger edge history
	always_ff @(posedge clock)
	begin
		if (rst)
			trig_prev_ff <= 1'b0;
		else
			trig_prev_ff <= sync2_ff.position_trigger;
	end

	assign trig_rise = sync2_ff.position_trigger & ~trig_prev_ff;

	////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states
	// Writes land at the edge where ready is sampled high
	assign wr_en = psel & penable & pwrite & pready_ff;
	assign rd_en = psel & ~penable & ~pwrite;

	always_comb
	begin
		unique case (pwdata[7:0])
			mode_sel_pkg::CODE_PULSE_SPEED,
			mode_sel_pkg::CODE_PULSE_TORQUE,
			mode_sel_pkg::CODE_TABLE_SPEED,
			mode_sel_pkg::CODE_TABLE_TORQUE,
			mode_sel_pkg::CODE_SPEED_TORQUE,
			mode_sel_pkg::CODE_PULSE_TABLE,
			mode_sel_pkg::CODE_PULSE_TABLE_SPEED,
			mode_sel_pkg::CODE_PULSE_TABLE_TORQUE: code_ok = 1'b1;
			default: code_ok = 1'b0;
		endcase
		if (pwdata[mode_sel_pkg::MODE_ZERO_TORQUE_BIT])
			code_ok = 1'b0;
	end

	// Mode code, only a listed combination is taken
	always_ff @(posedge clock)
	begin
		if (rst)
			mode_ff <= mode_sel_pkg::RST_MODE;
		else if (wr_en && paddr == mode_sel_pkg::ADDR_MODE && code_ok)
			mode_ff <= pwdata[7:0];
	end

	// Limit enables
	always_ff @(posedge clock)
	begin
		if (rst)
			limit_ff <= mode_sel_pkg::RST_LIMIT;
		else if (wr_en && paddr == mode_sel_pkg::ADDR_LIMIT)
			limit_ff <= pwdata[1:0];
	end

	// Speed cap value
	always_ff @(posedge clock)
	begin
		if (rst)
			max_speed_ff <= mode_sel_pkg::RST_MAX_SPEED;
		else if (wr_en && paddr == mode_sel_pkg::ADDR_MAX_SPEED)
			max_speed_ff <= pwdata[15:0];
	end

	// Which preset select lines are wired
	always_ff @(posedge clock)
	begin
		if (rst)
			avail_ff <= mode_sel_pkg::RST_AVAIL;
		else if (wr_en && paddr == mode_sel_pkg::ADDR_AVAIL)
			avail_ff <= pwdata[1:0];
	end

	// Ready pulse in the access phase, never a wait state
	always_ff @(posedge clock)
	begin
		if (rst)
			pready_ff <= 1'b0;
		else
			pready_ff <= psel & ~penable;
	end

	// Error answer decided in the setup cycle, stands with ready
	always_ff @(posedge clock)
	begin
		if (rst)
			pslverr_ff <= 1'b0;
		else if (psel & ~penable)
		begin
			unique case (paddr)
				mode_sel_pkg::ADDR_MODE:
					pslverr_ff <= pwrite & ~code_ok;
				mode_sel_pkg::ADDR_LIMIT,
				mode_sel_pkg::ADDR_MAX_SPEED,
				mode_sel_pkg::ADDR_AVAIL:
					pslverr_ff <= 1'b0;
				// Status and target are read-only
				mode_sel_pkg::ADDR_STATUS,
				mode_sel_pkg::ADDR_POS_TARGET:
					pslverr_ff <= pwrite;
				default:
					pslverr_ff <= 1'b1;
			endcase
		end
		else
			pslverr_ff <= 1'b0;
	end

	// Read data captured in the setup cycle so that it stands with ready
	always_ff @(posedge clock)
	begin
		if (rst)
			prdata_ff <= '0;
		else if (rd_en)
		begin
			unique case (paddr)
				mode_sel_pkg::ADDR_MODE:
					prdata_ff <= {24'h0, mode_ff};
				mode_sel_pkg::ADDR_LIMIT:
					prdata_ff <= {30'h0, limit_ff};
				mode_sel_pkg::ADDR_MAX_SPEED:
					prdata_ff <= {16'h0, max_speed_ff};
				mode_sel_pkg::ADDR_AVAIL:
					prdata_ff <= {30'h0, avail_ff};
				mode_sel_pkg::ADDR_STATUS:
					prdata_ff <= {27'h0, armed_ff, servo_s2_ff, out_ff.loop};
				mode_sel_pkg::ADDR_POS_TARGET:
					prdata_ff <= {26'h0, target_ff};
				default:
					prdata_ff <= '0;
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	////////////////////////////////////////////////////////////////////
	// Position-side decision per mode
	always_comb
	begin
		in_position = 1'b0;
		unique case (mode_ff)
			mode_sel_pkg::CODE_PULSE_SPEED,
			mode_sel_pkg::CODE_TABLE_SPEED,
			mode_sel_pkg::CODE_PULSE_TABLE_SPEED:
				in_position = ~sync2_ff.speed_or_position;
			mode_sel_pkg::CODE_PULSE_TORQUE,
			mode_sel_pkg::CODE_TABLE_TORQUE,
			mode_sel_pkg::CODE_PULSE_TABLE_TORQUE:
				in_position = ~sync2_ff.torque_or_position;
			mode_sel_pkg::CODE_PULSE_TABLE:
				in_position = 1'b1;
			default:
				in_position = 1'b0;
		endcase
	end

	// Trigger arm and target latch on a trigger rising edge while in position
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			prev_position_ff <= 1'b0;
			armed_ff <= 1'b0;
			target_ff <= '0;
		end
		else
		begin
			prev_position_ff <= in_position;
			if (!in_position)
				armed_ff <= 1'b0;
			else if (trig_rise)
			begin
				armed_ff <= 1'b1;
				target_ff <= sync2_ff.position_preset_select;
			end
			else if (!prev_position_ff)
				armed_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Loop selection
	always_comb
	begin
		nxt_loop = mode_sel_pkg::LOOP_SPEED;
		unique case (mode_ff)
			mode_sel_pkg::CODE_SPEED_TORQUE:
				nxt_loop = sync2_ff.speed_or_torque ? mode_sel_pkg::LOOP_TORQUE
					: mode_sel_pkg::LOOP_SPEED;
			mode_sel_pkg::CODE_PULSE_SPEED,
			mode_sel_pkg::CODE_TABLE_SPEED,
			mode_sel_pkg::CODE_PULSE_TABLE_SPEED:
				nxt_loop = mode_sel_pkg::LOOP_SPEED;
			default:
				nxt_loop = mode_sel_pkg::LOOP_TORQUE;
		endcase
		if (in_position)
		begin
			if (!armed_ff && mode_ff != mode_sel_pkg::CODE_PULSE_TABLE)
				nxt_loop = mode_sel_pkg::LOOP_HOLD;
			else if (mode_ff == mode_sel_pkg::CODE_TABLE_SPEED
				|| mode_ff == mode_sel_pkg::CODE_TABLE_TORQUE)
				nxt_loop = mode_sel_pkg::LOOP_TABLE;
			else if (mode_ff == mode_sel_pkg::CODE_PULSE_SPEED
				|| mode_ff == mode_sel_pkg::CODE_PULSE_TORQUE)
				nxt_loop = mode_sel_pkg::LOOP_PULSE;
			else
				nxt_loop = sync2_ff.table_or_pulse ? mode_sel_pkg::LOOP_TABLE
					: mode_sel_pkg::LOOP_PULSE;
		end
	end

	// Command sources from preset selects
	always_comb
	begin
		unique case (avail_ff[mode_sel_pkg::AVAIL_SPEED_BIT] ?
			sync2_ff.speed_preset_select : 2'h0)
			2'h0: nxt_speed_src = mode_sel_pkg::SRC_ANALOG;
			2'h1: nxt_speed_src = mode_sel_pkg::SRC_PRESET1;
			2'h2: nxt_speed_src = mode_sel_pkg::SRC_PRESET2;
			2'h3: nxt_speed_src = mode_sel_pkg::SRC_PRESET3;
		endcase
		unique case (avail_ff[mode_sel_pkg::AVAIL_TORQUE_BIT] ?
			sync2_ff.torque_preset_select : 2'h0)
			2'h0: nxt_torque_src = mode_sel_pkg::SRC_ANALOG;
			2'h1: nxt_torque_src = mode_sel_pkg::SRC_PRESET1;
			2'h2: nxt_torque_src = mode_sel_pkg::SRC_PRESET2;
			2'h3: nxt_torque_src = mode_sel_pkg::SRC_PRESET3;
		endcase
		if (!servo_s2_ff)
			nxt_torque_src = mode_sel_pkg::SRC_ZERO;
	end

	////////////////////////////////////////////////////////////////////
	// Output register
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			out_ff <= '0;
			out_ff.loop <= mode_sel_pkg::LOOP_HOLD;
			out_ff.torque_src <= mode_sel_pkg::SRC_ZERO;
		end
		else
		begin
			out_ff.loop <= nxt_loop;
			out_ff.speed_src <= nxt_speed_src;
			out_ff.torque_src <= nxt_torque_src;
			out_ff.speed_limit_on <= limit_ff[mode_sel_pkg::LIMIT_SPEED_BIT]
				& (nxt_loop == mode_sel_pkg::LOOP_TORQUE);
			out_ff.torque_limit_on <= limit_ff[mode_sel_pkg::LIMIT_TORQUE_BIT]
				& (nxt_loop != mode_sel_pkg::LOOP_TORQUE);
			out_ff.speed_cap <= max_speed_ff;
			out_ff.position_index <= target_ff;
			out_ff.position_move <= armed_ff & in_position;
		end
	end

	assign sel_out = out_ff;

endmodule

// file: tb/ctrl_model.sv
// Model of the external controller that drives the selection lines
`timescale 1ns/100ps
module ctrl_model
(
	input wire logic clock,
	input wire mode_sel_pkg::sel_in_t want,
	output mode_sel_pkg::sel_in_t sel_in
);
	initial sel_in = '0;

	// analog and pulse preferred
	// Lines change only just after a clock edge
	always @(posedge clock)
	begin
		sel_in <= want;
	end
endmodule

// file: tb/mode_sel_checker.sv
// Checker of bus timing and loop selection relations at the selector ports
`timescale 1ns/100ps
module mode_sel_checker
(
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic servo_enable,
	input wire mode_sel_pkg::sel_in_t sel_in,
	input wire mode_sel_pkg::sel_out_t sel_out
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	// Wait-free single-cycle answer
	ready_next_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	code_refuse_a:
		assert property (psel && !penable && pwrite && paddr == 12'h000
		&& !(pwdata[7:0] inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h0f})
		|=> pslverr) else $error("illegal mode code accepted");
	zero_variant_a:
		assert property (psel && !penable && pwrite && paddr == 12'h000 && pwdata[8] |=> pslverr)
		else $error("zero-analog variant accepted");

	////////////////////////////////////////////////////////////////////////////////
	// Limit gating against the active loop
	speed_lim_a:
		assert property (sel_out.speed_limit_on |-> sel_out.loop == mode_sel_pkg::LOOP_TORQUE)
		else $error("speed limit outside torque loop");
	torque_lim_a:
		assert property (sel_out.torque_limit_on |-> sel_out.loop != mode_sel_pkg::LOOP_TORQUE)
		else $error("torque limit in torque loop");
	zero_torque_a:
		assert property (!servo_enable [*4] |=> sel_out.torque_src == mode_sel_pkg::SRC_ZERO)
		else $error("torque source picked while disabled");

	////////////////////////////////////////////////////////////////////////////////
	// Position moves only from a trigger edge
	move_edge_a:
		assert property ($rose(sel_out.position_move) |->
		$past(sel_in.position_trigger, 4) && !$past(sel_in.position_trigger, 5))
		else $error("move without trigger edge");
	hold_stop_a:
		assert property (sel_out.loop == mode_sel_pkg::LOOP_HOLD |-> !sel_out.position_move)
		else $error("move while holding");
	move_loop_a:
		assert property (sel_out.position_move |->
		sel_out.loop inside {mode_sel_pkg::LOOP_PULSE, mode_sel_pkg::LOOP_TABLE})
		else $error("move outside position loop");
endmodule

bind servo_control_mode_selector mode_sel_checker chk (.clock(clock), .rst(rst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .servo_enable(servo_enable), .sel_in(sel_in),
	.sel_out(sel_out));

// file: tb/test_servo_control_mode_selector.sv
// Self-checking bench for the control mode selector
`timescale 1ns/100ps
module test_servo_control_mode_selector;
	logic clock, rst, psel, penable, pwrite, servo_enable, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [31:0] seed = 32'h00000059;
	mode_sel_pkg::sel_in_t want, sel_in;
	mode_sel_pkg::sel_out_t sel_out;
	logic [32:0] exp_rd[$];
	int qf[$];
	logic [15:0] qv[$];
	int fails, n_checks;
	logic [7:0] codes [8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e, 8'h0f};

	servo_control_mode_selector DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .servo_enable(servo_enable), .sel_in(sel_in), .sel_out(sel_out));
	ctrl_model partner (.clock(clock), .want(want), .sel_in(sel_in));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [15:0] fld(input int f);
		case (f)
			0: return {13'h0, sel_out.loop};
			1: return {13'h0, sel_out.torque_src};
			2: return {15'h0, sel_out.position_move};
			3: return {10'h0, sel_out.position_index};
			4: return {15'h0, sel_out.speed_limit_on};
			5: return {15'h0, sel_out.torque_limit_on};
			7: return {13'h0, sel_out.speed_src};
			default: return sel_out.speed_cap;
		endcase
	endfunction

	task automatic cmp_rd(input logic [32:0] g, input logic [32:0] e);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cmp_sel(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// One bus transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		exp_rd.push_back({e, 32'h0});
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		exp_rd.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic chk(input int f, input logic [15:0] v);
		qf.push_back(f);
		qv.push_back(v);
	endtask

	// Release the bus and let the selection lines settle
	task automatic settle();
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (6) @(posedge clock);
	endtask

	task automatic side(input logic tp, input logic v);
		want.speed_or_position <= v & !tp;
		want.torque_or_position <= v & tp;
	endtask

	// Toggle between a position half and its partner loop
	task automatic pos_case(input logic [7:0] c, input logic tp, input logic [2:0] o,
		input logic [2:0] pl);
		r = xs();
		wr(mode_sel_pkg::ADDR_MODE, {24'h0, c}, 1'b0);
		side(tp, 1'b1);
		want.position_trigger <= 1'b1;
		settle();
		chk(0, o);
		chk(2, 0);
		side(tp, 1'b0);
		want.position_trigger <= 1'b0;
		settle();
		chk(0, mode_sel_pkg::LOOP_HOLD);
		want.position_preset_select <= r[5:0];
		want.position_trigger <= 1'b1;
		settle();
		chk(0, pl);
		chk(3, r[5:0]);
		chk(2, 1);
		side(tp, 1'b1);
		want.position_trigger <= 1'b0;
		settle();
		chk(0, o);
		$display("test position %h done", c);
	endtask

	task automatic report_and_stop();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Clock, monitor and watchdog
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock)
	begin
		if (psel && penable && pready === 1'b1)
			cmp_rd({pslverr, pwrite ? 32'h0 : prdata}, exp_rd.pop_front());
		while (qf.size() > 0)
			cmp_sel(fld(qf.pop_front()), qv.pop_front());
	end

	initial
	begin
		repeat (5000) @(posedge clock);
		fails++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		servo_enable = 1'b0;
		want = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd(mode_sel_pkg::ADDR_MODE, {25'h0, mode_sel_pkg::RST_MODE});
		rd(mode_sel_pkg::ADDR_LIMIT, {31'h0, mode_sel_pkg::RST_LIMIT});
		rd(mode_sel_pkg::ADDR_MAX_SPEED, {17'h0, mode_sel_pkg::RST_MAX_SPEED});
		rd(mode_sel_pkg::ADDR_AVAIL, {31'h0, mode_sel_pkg::RST_AVAIL});
		rd(12'h018, 33'h100000000);
		wr(mode_sel_pkg::ADDR_STATUS, 32'h0, 1'b1);
		foreach (codes[i])
		begin
			wr(mode_sel_pkg::ADDR_MODE, {24'h0, codes[i]}, 1'b0);
			rd(mode_sel_pkg::ADDR_MODE, {25'h0, codes[i]});
		end
		wr(mode_sel_pkg::ADDR_MODE, 32'h0b, 1'b1);
		rd(mode_sel_pkg::ADDR_MODE, {25'h0, 8'h0f});
		settle();
		$display("test registers done");
		pos_case(8'h06, 1'b0, mode_sel_pkg::LOOP_SPEED, mode_sel_pkg::LOOP_PULSE);
		pos_case(8'h09, 1'b1, mode_sel_pkg::LOOP_TORQUE, mode_sel_pkg::LOOP_TABLE);
		want.table_or_pulse <= 1'b1;
		pos_case(8'h0f, 1'b1, mode_sel_pkg::LOOP_TORQUE, mode_sel_pkg::LOOP_TABLE);
		wr(mode_sel_pkg::ADDR_MODE, 32'h0a, 1'b0);
		wr(mode_sel_pkg::ADDR_LIMIT, 32'h3, 1'b0);
		want.speed_or_torque <= 1'b1;
		want.torque_preset_select <= 2'b01;
		settle();
		chk(0, mode_sel_pkg::LOOP_TORQUE);
		chk(1, mode_sel_pkg::SRC_ZERO);
		chk(4, 1);
		chk(5, 0);
		servo_enable <= 1'b1;
		settle();
		chk(1, mode_sel_pkg::SRC_PRESET1);
		want.torque_preset_select <= 2'b00;
		settle();
		chk(1, mode_sel_pkg::SRC_ANALOG);
		wr(mode_sel_pkg::ADDR_MODE, 32'h10a, 1'b1);
		rd(mode_sel_pkg::ADDR_MODE, {25'h0, 8'h0a});
		settle();
		chk(1, mode_sel_pkg::SRC_ANALOG);
		want.speed_or_torque <= 1'b0;
		want.speed_preset_select <= 2'b10;
		want.torque_preset_select <= 2'b11;
		settle();
		chk(0, mode_sel_pkg::LOOP_SPEED);
		chk(7, mode_sel_pkg::SRC_PRESET2);
		chk(1, mode_sel_pkg::SRC_PRESET3);
		chk(4, 0);
		chk(5, 1);
		wr(mode_sel_pkg::ADDR_AVAIL, 32'h0, 1'b0);
		wr(mode_sel_pkg::ADDR_LIMIT, 32'h0, 1'b0);
		settle();
		chk(7, mode_sel_pkg::SRC_ANALOG);
		chk(1, mode_sel_pkg::SRC_ANALOG);
		chk(5, 0);
		$display("test speed torque done");
		r = xs();
		wr(mode_sel_pkg::ADDR_MAX_SPEED, {16'h0, r[15:0]}, 1'b0);
		rd(mode_sel_pkg::ADDR_MAX_SPEED, {17'h0, r[15:0]});
		settle();
		chk(6, r[15:0]);
		settle();
		$display("test speed cap done");
		report_and_stop();
	end
endmodule
